// ===== audio_status_consts.vh
// constants for the codec status and flag register bank
// assumes an internal register port from the control-bus slave, 7-bit register index
`ifndef AUDIO_STATUS_CONSTS_VH
`define AUDIO_STATUS_CONSTS_VH
`define ADDR_OVERFLOW      7'h27
`define ADDR_RSVD_A        7'h28
`define ADDR_RSVD_B        7'h29
`define ADDR_RSVD_C        7'h2A
`define ADDR_RSVD_D        7'h2B
`define ADDR_PLAY_LATCHED  7'h2C
`define ADDR_REC_LATCHED   7'h2D
`define ADDR_PLAY_LIVE     7'h2E
`define OVF_RW_MASK        8'h15
`define REC_RW_MASK        8'hA3
`define RESET_FLAGS        8'h00
`define RESET_RSVD         8'h00
`define CLOCK_HZ           25000000
`define PULSE_HIGH_US      2000
`define PULSE_PERIOD_US    4000
`define PULSE_HIGH_CYCLES  ((`CLOCK_HZ / 1000000) * `PULSE_HIGH_US)
`define PULSE_PERIOD_CYCLES ((`CLOCK_HZ / 1000000) * `PULSE_PERIOD_US)
`endif

// ===== audio_status_flag_bank.v
// status and flag register bank with interrupt pulse output
// holds the overflow flags, the latched and live event flags and the reserved slots
// assumes single clock, sources on clock except short-circuit, button and headset pins which are synchronised
// assumes a register port that strobes one read or write per cycle
`timescale 1ns/1ps
`include "audio_status_consts.vh"
module audio_status_flag_bank #(
  parameter PULSE_HIGH_CYCLES   = `PULSE_HIGH_CYCLES,
  parameter PULSE_PERIOD_CYCLES = `PULSE_PERIOD_CYCLES
) (
  input  wire       clock,
  input  wire       reset,
  input  wire [6:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       dac_left_overflow,
  input  wire       dac_right_overflow,
  input  wire       dac_shifter_overflow,
  input  wire       adc_overflow,
  input  wire       adc_shifter_overflow,
  input  wire       short_circuit_pin,
  input  wire       button_pin,
  input  wire       headset_present_pin,
  input  wire       compressor_left_above,
  input  wire       compressor_right_above,
  input  wire       gain_control_noise_below,
  input  wire       record_engine_std_port,
  input  wire       record_engine_aux_port,
  input  wire       dc_measure_ready,
  input  wire       playback_engine_std_port,
  input  wire       playback_engine_aux_port,
  input  wire       repeat_pulse_mode,
  output wire       first_interrupt_output
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_HIGH = 3'h2;
  localparam [2:0] ST_LOW  = 3'h4;

  function hit;
    input [6:0] a;
    input [6:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // two-stage synchronisers for the analog detector pins
  wire [2:0] pin_raw = {headset_present_pin, button_pin, short_circuit_pin};
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin_sync
      always @(posedge clock) begin
        if (reset) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate
  wire short_s   = sync2_reg[0];
  wire button_s  = sync2_reg[1];
  wire headset_s = sync2_reg[2];
  reg  headset_prev_reg;
  wire headset_changed = headset_s ^ headset_prev_reg;

  // latched flag registers
  reg [7:0] ovf_reg;
  reg [7:0] play_lat_reg;
  reg [7:0] rec_lat_reg;

  // reserved slots are plain storage, indexed by the low two address bits
  reg  [7:0] rsvd_mem [0:3];
  wire       rsvd_wr = reg_wr && (reg_addr[6:2] == `ADDR_RSVD_A >> 2);

  wire rd_ovf  = reg_rd && hit(reg_addr, `ADDR_OVERFLOW);
  wire rd_play = reg_rd && hit(reg_addr, `ADDR_PLAY_LATCHED);
  wire rd_rec  = reg_rd && hit(reg_addr, `ADDR_REC_LATCHED);
  wire wr_ovf  = reg_wr && hit(reg_addr, `ADDR_OVERFLOW);
  wire wr_rec  = reg_wr && hit(reg_addr, `ADDR_REC_LATCHED);

  wire [7:0] ovf_set = {dac_left_overflow,
                        dac_right_overflow,
                        dac_shifter_overflow,
                        1'b0,
                        adc_overflow,
                        1'b0,
                        adc_shifter_overflow,
                        1'b0};
  wire [7:0] play_set = {short_s,
                         1'b0,
                         button_s,
                         headset_changed,
                         compressor_left_above,
                         compressor_right_above,
                         2'b00};
  wire [7:0] rec_set = {1'b0,
                        gain_control_noise_below,
                        1'b0,
                        record_engine_std_port,
                        record_engine_aux_port,
                        dc_measure_ready,
                        2'b00};
  wire [7:0] play_live = {short_s,
                          1'b0,
                          button_s,
                          headset_s,
                          compressor_left_above,
                          compressor_right_above,
                          playback_engine_std_port,
                          playback_engine_aux_port};

  // sticky flags: read clears, a set in the same cycle wins
  function sticky_bit;
    input held;
    input set;
    input clear;
    begin
      sticky_bit = set | (held & ~clear);
    end
  endfunction

  // read/write reserved bits are plain storage that a write replaces
  function store_bit;
    input held;
    input write;
    input data;
    begin
      store_bit = write ? data : held;
    end
  endfunction

  wire [7:0] ovf_next;
  wire [7:0] rec_next;
  wire [7:0] play_next;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : flag_bit
      if (((`OVF_RW_MASK >> b) & 1) != 0) begin : ovf_store
        assign ovf_next[b] = store_bit(ovf_reg[b], wr_ovf, reg_wdata[b]);
      end else begin : ovf_sticky
        assign ovf_next[b] = sticky_bit(ovf_reg[b], ovf_set[b], rd_ovf);
      end
      if (((`REC_RW_MASK >> b) & 1) != 0) begin : rec_store
        assign rec_next[b] = store_bit(rec_lat_reg[b], wr_rec, reg_wdata[b]);
      end else begin : rec_sticky
        assign rec_next[b] = sticky_bit(rec_lat_reg[b], rec_set[b], rd_rec);
      end
      assign play_next[b] = sticky_bit(play_lat_reg[b], play_set[b], rd_play);
    end
  endgenerate

  // flag registers take their next values every cycle
  always @(posedge clock) begin
    if (reset) begin
      ovf_reg <= `RESET_FLAGS;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      play_lat_reg <= `RESET_FLAGS;
    end else begin
      play_lat_reg <= play_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      rec_lat_reg <= `RESET_FLAGS;
    end else begin
      rec_lat_reg <= rec_next;
    end
  end

  // previous synchronised headset level, so a change in either direction is seen
  always @(posedge clock) begin
    if (reset) begin
      headset_prev_reg <= 1'b0;
    end else begin
      headset_prev_reg <= headset_s;
    end
  end

  // reserved storage is written whole
  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : rsvd_slot
      always @(posedge clock) begin
        if (reset) begin
          rsvd_mem[s] <= `RESET_RSVD;
        end else if (rsvd_wr && reg_addr[1:0] == s) begin
          rsvd_mem[s] <= reg_wdata;
        end
      end
    end
  endgenerate

  // read data: value before the clear, registered
  reg [7:0] read_mux;
  always @* begin
    case (reg_addr)
      `ADDR_OVERFLOW:     read_mux = ovf_reg;
      `ADDR_RSVD_A:       read_mux = rsvd_mem[0];
      `ADDR_RSVD_B:       read_mux = rsvd_mem[1];
      `ADDR_RSVD_C:       read_mux = rsvd_mem[2];
      `ADDR_RSVD_D:       read_mux = rsvd_mem[3];
      `ADDR_PLAY_LATCHED: read_mux = play_lat_reg;
      `ADDR_REC_LATCHED:  read_mux = rec_lat_reg;
      `ADDR_PLAY_LIVE:    read_mux = play_live;
      default:            read_mux = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  // interrupt pulse generator: one high phase in single mode, high/low
  // phases in repeat mode until both latched registers have been read
  wire [7:0] play_rise = play_set & ~play_lat_reg;
  wire [7:0] rec_rise  = rec_set & ~rec_lat_reg & ~`REC_RW_MASK;
  wire       new_event = (|play_rise) | (|rec_rise);
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [16:0] count_reg;
  reg  [16:0] count_next;
  reg        seen_play_reg;
  reg        seen_rec_reg;
  wire       both_read = (seen_play_reg || rd_play) && (seen_rec_reg || rd_rec);
  localparam integer HIGH_LAST_W = PULSE_HIGH_CYCLES - 1;
  localparam integer LOW_LAST_W  = PULSE_PERIOD_CYCLES - PULSE_HIGH_CYCLES - 1;
  localparam [16:0]  HIGH_LAST   = HIGH_LAST_W[16:0];
  localparam [16:0]  LOW_LAST    = LOW_LAST_W[16:0];
  wire       high_done = (count_reg == HIGH_LAST);
  wire       low_done  = (count_reg == LOW_LAST);

  // next state and phase counter

  always @* begin
    state_next = state_reg;
    count_next = count_reg + 17'h00001;
    case (state_reg)
      ST_IDLE: begin
        count_next = 17'h00000;
        if (new_event) state_next = ST_HIGH;
      end
      ST_HIGH: begin
        if (high_done) begin
          count_next = 17'h00000;
          if (repeat_pulse_mode && !both_read) state_next = ST_LOW;
          else state_next = ST_IDLE;
        end
      end
      ST_LOW: begin
        if (both_read) begin
          state_next = ST_IDLE;
          count_next = 17'h00000;
        end else if (low_done) begin
          state_next = ST_HIGH;
          count_next = 17'h00000;
        end
      end
      default: begin
        state_next = ST_IDLE;
        count_next = 17'h00000;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      count_reg     <= 17'h00000;
    end else begin
      state_reg     <= state_next;
      count_reg     <= count_next;
    end
  end

  // read tracking for repeat mode, restarted by every new event
  always @(posedge clock) begin
    if (reset) begin
      seen_play_reg <= 1'b0;
      seen_rec_reg  <= 1'b0;
    end else begin
      seen_play_reg <= new_event ? 1'b0 : (seen_play_reg | rd_play);
      seen_rec_reg  <= new_event ? 1'b0 : (seen_rec_reg | rd_rec);
    end
  end

  assign first_interrupt_output = state_reg[1];
endmodule

// ===== flag_bank_properties.sv
// checker on the status flag bank ports
// assumes same-clock sources and read data one edge after the strobe
`timescale 1ns/1ps
module flag_bank_properties #(
  parameter PULSE_HIGH_CYCLES = 4
) (
  input wire       clock,
  input wire       reset,
  input wire [6:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       dac_left_overflow,
  input wire       compressor_right_above,
  input wire       record_engine_std_port,
  input wire       dc_measure_ready,
  input wire       playback_engine_std_port,
  input wire       first_interrupt_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire        rd_ovf = reg_rd && reg_addr == 7'h27;
  wire        rd_pl  = reg_rd && reg_addr == 7'h2C;
  wire        rd_rec = reg_rd && reg_addr == 7'h2D;
  wire        rd_liv = reg_rd && reg_addr == 7'h2E;
  reg  [31:0] run_reg;
  // length of the current high run of the interrupt output
  always @(posedge clock)
    run_reg <= (reset || !first_interrupt_output) ? 32'h0 : run_reg + 32'h1;
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  live_engine_a: assert property (rd_liv |=> reg_rdata[1] == $past(playback_engine_std_port))
    else $error("live engine bit wrong");
  live_comp_a: assert property (rd_liv |=> reg_rdata[2] == $past(compressor_right_above))
    else $error("live compressor bit wrong");
  ovf_left_a: assert property (dac_left_overflow ##1 !rd_ovf ##1 rd_ovf |=> reg_rdata[7])
    else $error("overflow flag lost");
  comp_latch_a: assert property (compressor_right_above ##1 !rd_pl ##1 rd_pl |=> reg_rdata[2])
    else $error("compressor flag lost");
  rec_engine_a: assert property (record_engine_std_port ##1 !rd_rec ##1 rd_rec |=> reg_rdata[4])
    else $error("engine flag lost");
  dc_ready_a: assert property (dc_measure_ready ##1 !rd_rec ##1 rd_rec |=> reg_rdata[2])
    else $error("measurement flag lost");
  pulse_width_a: assert property ($fell(first_interrupt_output) |-> run_reg == PULSE_HIGH_CYCLES)
    else $error("pulse width wrong");
  cover property ($rose(first_interrupt_output));
  cover property (rd_liv);
  cover property (rd_rec);
endmodule
bind audio_status_flag_bank flag_bank_properties #(.PULSE_HIGH_CYCLES(PULSE_HIGH_CYCLES))
  props_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dac_left_overflow(dac_left_overflow),
  .compressor_right_above(compressor_right_above), .dc_measure_ready(dc_measure_ready),
  .record_engine_std_port(record_engine_std_port), .first_interrupt_output(first_interrupt_output),
  .playback_engine_std_port(playback_engine_std_port));

// ===== status_host_model.sv
// host model on the register port of the flag bank
// assumes it is the only requester and is called on a clock edge
`timescale 1ns/1ps
module status_host_model (
  input  wire       clock,
  output reg  [6:0] reg_addr = 7'h00,
  output reg        reg_wr = 1'b0,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        reg_rd = 1'b0,
  input  wire [7:0] reg_rdata
);
  task xfer(input w, input [6:0] a, input [7:0] d, output [7:0] q);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= a == 7'h27 ? d & 8'hEA : a == 7'h2D ? d & 8'h5C :
                 a[6:2] == 5'h0A ? 8'h00 : d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clock);
    q = reg_rdata;
  endtask
endmodule

// ===== audio_status_flag_bank_tb.sv
// self-checking bench of the status flag bank driven through the host model
// assumes one 25 MHz clock; pulse counts shortened to 4 and 10 cycles
`timescale 1ns/1ps
module audio_status_flag_bank_tb;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg  [17:0] src = 18'h00000;
  reg         irq_q = 1'b0;
  reg  [31:0] seed = 32'hA9AE;
  reg  [7:0]  d;
  integer     err_count = 0, comparisons = 0, rises = 0, r0, i;
  wire [6:0]  reg_addr;
  wire        reg_wr, reg_rd, irq;
  wire [7:0]  reg_wdata, reg_rdata;
  audio_status_flag_bank #(.PULSE_HIGH_CYCLES(4), .PULSE_PERIOD_CYCLES(10)) dut_u (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_left_overflow(src[4]),
    .dac_right_overflow(src[3]), .dac_shifter_overflow(src[2]), .adc_overflow(src[1]),
    .adc_shifter_overflow(src[0]), .short_circuit_pin(src[7]), .button_pin(src[6]),
    .headset_present_pin(src[5]), .compressor_left_above(src[9]), .compressor_right_above(src[8]),
    .gain_control_noise_below(src[13]), .record_engine_std_port(src[12]),
    .record_engine_aux_port(src[11]), .dc_measure_ready(src[10]), .playback_engine_std_port(src[15]),
    .playback_engine_aux_port(src[14]), .repeat_pulse_mode(src[16]), .first_interrupt_output(irq));
  status_host_model host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    irq_q <= irq;
    rises <= rises + (irq && !irq_q);
  end
  function [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk(input [6:0] a, input [7:0] e);
    host_u.xfer(1'b0, a, 8'h00, d);
    cmp($sformatf("reg %h", a), e, d);
  endtask
  task pulse(input [17:0] v, input integer n);
    src <= v;
    repeat (1) @(posedge clock);
    src <= v & 18'h10000;
    repeat (n) @(posedge clock);
  endtask
  task complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (i = 8'h27; i <= 8'h2F; i = i + 1)
      chk(i, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      pulse(18'h1 << i, 0);
      chk(7'h27, 40'h8040200802 >> (i * 8));
      chk(7'h27, 8'h00);
    end
    host_u.xfer(1'b1, 7'h27, 8'hFF, d);
    host_u.xfer(1'b1, 7'h2D, 8'hFF, d);
    host_u.xfer(1'b1, 7'h28, 8'h5A, d);
    chk(7'h27, 8'h00);
    chk(7'h2D, 8'h00);
    chk(7'h28, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      pulse({seed[3:2], 4'h0, seed[1:0], 8'h00}, 0);
      chk(7'h2E, 8'h00);
      src <= {seed[3:2], 4'h0, seed[1:0], 8'h00};
      chk(7'h2E, {4'h0, seed[1:0], seed[3:2]});
    end
    src <= 18'h00000;
    host_u.xfer(1'b0, 7'h2C, 8'h00, d);
    pulse(18'h00100, 0);
    chk(7'h2C, 8'h04);
    chk(7'h2C, 8'h00);
    src <= 18'h000E0;
    repeat (4) @(posedge clock);
    chk(7'h2E, 8'hB0);
    chk(7'h2C, 8'hB0);
    src <= 18'h00000;
    repeat (4) @(posedge clock);
    chk(7'h2C, 8'hB0);
    chk(7'h2C, 8'h00);
    chk(7'h2E, 8'h00);
    pulse(18'h03C00, 0);
    chk(7'h2D, 8'h5C);
    chk(7'h2D, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      src <= {i[0], 16'h0000};
      repeat (20) @(posedge clock);
      r0 = rises;
      pulse({i[0], 16'h0400}, 25);
      cmp("pulse count", 1 + 2 * i, rises - r0);
      host_u.xfer(1'b0, 7'h2C, 8'h00, d);
      chk(7'h2D, 8'h04);
    end
    repeat (10) @(posedge clock);
    r0 = rises;
    repeat (30) @(posedge clock);
    cmp("pulse count", 8'h00, rises - r0);
    complete_run;
  end
endmodule
